/* src/psbs_pkg.sv */
package psbs_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_STATUS    = 8'h00;
   localparam logic [7:0] OFS_WRITE_TARGET_ADDRESS     = 8'h04;
   localparam logic [7:0] OFS_READ_TARGET_ADDRESS     = 8'h08;
   localparam logic [7:0] OFS_RDIN      = 8'h0C;
   localparam logic [7:0] OFS_CTRL      = 8'h10;
   localparam logic [7:0] OFS_OUTBUF    = 8'h14;
   localparam logic [7:0] OFS_INBUF     = 8'h18;
   localparam logic [7:0] OFS_SHARED_IN = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h24;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_IN_ALL_FULL  = 15;
   localparam int BIT_IN_OVF       = 14;
   localparam int BIT_IN_FULL_LO   = 8;
   localparam int BIT_OUT_ALL_EMPT = 7;
   localparam int BIT_OUT_UNF      = 6;
   localparam int BIT_OUT_EMPT_LO  = 0;
   localparam int BIT_CS_ACTIVE    = 14;
   localparam int ADDR_W           = 11;
   localparam int RDIN_W           = 16;
   localparam int BIT_SPLIT_EN     = 17;
   localparam int BIT_MODE_LO      = 8;
   localparam int BIT_IRQSEL_LO    = 13;
   localparam int BIT_STEP_LO      = 11;
   localparam int NBUF             = 4;

   // ----------------------------------------
   // Encodings and reset values
   // ----------------------------------------
   localparam logic [1:0] MODE_LEGACY   = 2'h0;
   localparam logic [1:0] MODE_ENHANCED = 2'h1;
   localparam logic [1:0] IRQSEL_BUF3   = 2'h2;
   localparam logic [1:0] STEP_AUTO     = 2'h3;
   localparam logic [1:0] LAST_BUF      = 2'h3;
   localparam logic [3:0] OUT_EMPTY_RST = 4'hF;

   // Interrupt status bits
   localparam int EV_OVF  = 0;
   localparam int EV_UNF  = 1;
   localparam int EV_BUF3 = 2;
   localparam int NEV     = 3;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [1:0] addr;
      logic [7:0] data;
   } psbs_host_t;

   typedef struct packed {
      logic       we;
      logic       re;
      logic [7:0] addr;
      logic [31:0] wdata;
   } psbs_bus_t;

endpackage

/* src/psbs_top.sv */
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module psbs_top
   import psbs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic [31:0]      reg_rdata,
   input  wire psbs_host_t  host,
   output logic [7:0]       host_rdata,
   output logic [ADDR_W:0]  port_address,
   output logic             port_chip_select_pin,
   output logic             irq
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [NBUF-1:0][7:0] in_buf_reg,  in_buf_next;
   logic [NBUF-1:0][7:0] out_buf_reg, out_buf_next;
   logic [NBUF-1:0]      in_full_reg, in_full_next;
   logic [NBUF-1:0]      out_empt_reg, out_empt_next;
   logic                 ovf_reg, ovf_next;
   logic                 unf_reg, unf_next;
   logic [1:0]           wptr_reg, wptr_next;
   logic [1:0]           rptr_reg, rptr_next;
   logic [ADDR_W-1:0]    write_target_address_reg, write_target_address_next;
   logic                 wcs_reg, wcs_next;
   logic [ADDR_W-1:0]    read_target_address_reg, read_target_address_next;
   logic                 rcs_reg, rcs_next;
   logic [RDIN_W-1:0]    rdin_reg, rdin_next;
   logic [RDIN_W-1:0]    shin_reg, shin_next;
   logic [31:0]          ctrl_reg, ctrl_next;
   logic [NEV-1:0]       ist_reg, ist_next;
   logic [NEV-1:0]       imask_reg, imask_next;
   logic [31:0]          rdata_reg, rdata_next;
   logic [7:0]           hdata_reg, hdata_next;

   logic [1:0] mode, irqsel, step;
   logic       split_en, slave_mode, auto_step;
   logic [1:0] wsel, rsel;
   logic [NEV-1:0] ev;
   logic       in_all_full, out_all_empty;

   function automatic logic [31:0] pack_status(input logic [3:0] f, input logic [3:0] e,
                                               input logic ov, input logic un);
      logic [31:0] s;
      s = '0;
      s[BIT_IN_ALL_FULL] = &f;
      s[BIT_IN_OVF] = ov;
      s[BIT_IN_FULL_LO +: NBUF] = f;
      s[BIT_OUT_ALL_EMPT] = &e;
      s[BIT_OUT_UNF] = un;
      s[BIT_OUT_EMPT_LO +: NBUF] = e;
      return s;
   endfunction

   assign mode       = ctrl_reg[BIT_MODE_LO +: 2];
   assign irqsel     = ctrl_reg[BIT_IRQSEL_LO +: 2];
   assign step       = ctrl_reg[BIT_STEP_LO +: 2];
   assign split_en   = ctrl_reg[BIT_SPLIT_EN];
   // Master modes ignore host strobes except host.rd on the split-buffer port address; only software accesses move the buffer flags
   assign slave_mode = (mode == MODE_LEGACY) || (mode == MODE_ENHANCED);
   assign auto_step  = (mode == MODE_LEGACY) && (step == STEP_AUTO);
   // Enhanced mode picks the buffer by the two host address lines
   assign wsel = (mode == MODE_ENHANCED) ? host.addr : wptr_reg;
   assign rsel = (mode == MODE_ENHANCED) ? host.addr : rptr_reg;
   assign in_all_full   = &in_full_reg;
   assign out_all_empty = &out_empt_reg;

   // ----------------------------------------
   // Buffers and flags
   // ----------------------------------------
   always_comb
   begin
      in_buf_next   = in_buf_reg;
      out_buf_next  = out_buf_reg;
      in_full_next  = in_full_reg;
      out_empt_next = out_empt_reg;
      ovf_next      = ovf_reg;
      unf_next      = unf_reg;
      wptr_next     = wptr_reg;
      rptr_next     = rptr_reg;
      hdata_next    = hdata_reg;
      ev            = '0;
      // Software side first so that a same-cycle host event wins
      if (reg_re && reg_addr == OFS_INBUF)
         in_full_next[reg_wdata[1:0]] = 1'b0;
      if (reg_we && reg_addr == OFS_OUTBUF)
      begin
         out_buf_next[reg_wdata[9:8]]  = reg_wdata[7:0];
         out_empt_next[reg_wdata[9:8]] = 1'b0;
      end
      if (reg_we && reg_addr == OFS_STATUS)
      begin
         if (reg_wdata[BIT_IN_OVF])  ovf_next = 1'b0;
         if (reg_wdata[BIT_OUT_UNF]) unf_next = 1'b0;
      end
      if (slave_mode && host.wr)
      begin
         if (in_full_reg[wsel])
         begin
            ovf_next   = 1'b1;
            ev[EV_OVF] = 1'b1;
         end
         else
         begin
            in_buf_next[wsel]  = host.data;
            in_full_next[wsel] = 1'b1;
         end
         if (auto_step) wptr_next = wptr_reg + 2'h1;
         if (wsel == LAST_BUF) ev[EV_BUF3] = 1'b1;
      end
      if (slave_mode && host.rd)
      begin
         hdata_next = out_buf_reg[rsel];
         if (out_empt_reg[rsel])
         begin
            unf_next   = 1'b1;
            ev[EV_UNF] = 1'b1;
         end
         out_empt_next[rsel] = 1'b1;
         if (auto_step) rptr_next = rptr_reg + 2'h1;
         if (rsel == LAST_BUF) ev[EV_BUF3] = 1'b1;
      end
      if (irqsel != IRQSEL_BUF3)
         ev[EV_BUF3] = 1'b0;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         in_buf_reg   <= '0;
         out_buf_reg  <= '0;
         in_full_reg  <= '0;
         out_empt_reg <= OUT_EMPTY_RST;
         ovf_reg      <= 1'b0;
         unf_reg      <= 1'b0;
         wptr_reg     <= '0;
         rptr_reg     <= '0;
         hdata_reg    <= '0;
      end
      else
      begin
         in_buf_reg   <= in_buf_next;
         out_buf_reg  <= out_buf_next;
         in_full_reg  <= in_full_next;
         out_empt_reg <= out_empt_next;
         ovf_reg      <= ovf_next;
         unf_reg      <= unf_next;
         wptr_reg     <= wptr_next;
         rptr_reg     <= rptr_next;
         hdata_reg    <= hdata_next;
      end
   end

   assign host_rdata = hdata_reg;

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   always_comb
   begin
      write_target_address_next = write_target_address_reg;
      wcs_next   = wcs_reg;
      read_target_address_next = read_target_address_reg;
      rcs_next   = rcs_reg;
      rdin_next  = rdin_reg;
      shin_next  = shin_reg;
      ctrl_next  = ctrl_reg;
      imask_next = imask_reg;
      ist_next   = ist_reg;
      rdata_next = '0;
      if (reg_we)
      begin
         case (reg_addr)
            OFS_WRITE_TARGET_ADDRESS:
            begin
               write_target_address_next = reg_wdata[ADDR_W-1:0];
               wcs_next   = reg_wdata[BIT_CS_ACTIVE];
            end
            OFS_READ_TARGET_ADDRESS:
            begin
               read_target_address_next = reg_wdata[ADDR_W-1:0];
               rcs_next   = reg_wdata[BIT_CS_ACTIVE];
            end
            OFS_RDIN:      rdin_next  = reg_wdata[RDIN_W-1:0];
            OFS_SHARED_IN: shin_next  = reg_wdata[RDIN_W-1:0];
            OFS_CTRL:      ctrl_next  = reg_wdata;
            OFS_IRQ_MASK:  imask_next = reg_wdata[NEV-1:0];
            OFS_IRQ_STAT:  ist_next   = ist_reg & ~reg_wdata[NEV-1:0];
            default:       ctrl_next  = ctrl_reg;
         endcase
      end
      // Host reads land in the data register of the active path
      if (slave_mode && host.rd)
      begin
         if (split_en)
            rdin_next = {8'h00, out_buf_reg[rsel]};
         else
            shin_next = {8'h00, out_buf_reg[rsel]};
      end
      ist_next = ist_next | ev;                                            // set wins over clear
      if (reg_re)
      begin
         case (reg_addr)
            OFS_STATUS:    rdata_next = pack_status(in_full_reg, out_empt_reg,
                                                    ovf_reg, unf_reg);
            OFS_WRITE_TARGET_ADDRESS:     rdata_next = {17'h00000, wcs_reg, 3'h0, write_target_address_reg};
            OFS_READ_TARGET_ADDRESS:     rdata_next = {17'h00000, rcs_reg, 3'h0, read_target_address_reg};
            OFS_RDIN:      rdata_next = {16'h0000, rdin_reg};
            OFS_SHARED_IN: rdata_next = {16'h0000, shin_reg};
            OFS_CTRL:      rdata_next = ctrl_reg;
            OFS_INBUF:     rdata_next = {24'h000000, in_buf_reg[reg_wdata[1:0]]};
            OFS_IRQ_STAT:  rdata_next = {29'h00000000, ist_reg};
            OFS_IRQ_MASK:  rdata_next = {29'h00000000, imask_reg};
            default:       rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         write_target_address_reg <= '0;
         wcs_reg   <= 1'b0;
         read_target_address_reg <= '0;
         rcs_reg   <= 1'b0;
         rdin_reg  <= '0;
         shin_reg  <= '0;
         ctrl_reg  <= '0;
         imask_reg <= '0;
         ist_reg   <= '0;
         rdata_reg <= '0;
      end
      else
      begin
         write_target_address_reg <= write_target_address_next;
         wcs_reg   <= wcs_next;
         read_target_address_reg <= read_target_address_next;
         rcs_reg   <= rcs_next;
         rdin_reg  <= rdin_next;
         shin_reg  <= shin_next;
         ctrl_reg  <= ctrl_next;
         imask_reg <= imask_next;
         ist_reg   <= ist_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign irq       = |(ist_reg & imask_reg);

   // ----------------------------------------
   // Port address
   // ----------------------------------------
   // Without split-buffer both directions share the write-address register
   always_comb
   begin
      if (split_en && host.rd)
      begin
         port_address         = {~rcs_reg & read_target_address_reg[ADDR_W-1], read_target_address_reg};
         port_chip_select_pin = rcs_reg;
      end
      else
      begin
         port_address         = {1'b0, write_target_address_reg};
         port_chip_select_pin = wcs_reg;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_ovf_sets: assert property (@(posedge clk) disable iff (!arst_n)
      slave_mode && host.wr && in_full_reg[wsel] |=> ovf_reg)
      else $error("overflow not flagged");
   a_unf_sets: assert property (@(posedge clk) disable iff (!arst_n)
      slave_mode && host.rd && out_empt_reg[rsel] |=> unf_reg)
      else $error("underflow not flagged");
   a_full_set: assert property (@(posedge clk) disable iff (!arst_n)
      slave_mode && host.wr |=> in_full_reg[$past(wsel)])
      else $error("full flag not set");
   a_full_clr: assert property (@(posedge clk) disable iff (!arst_n)
      reg_re && reg_addr == OFS_INBUF && !host.wr |=> !in_full_reg[$past(reg_wdata[1:0])])
      else $error("full flag not cleared");
   a_empty_clr: assert property (@(posedge clk) disable iff (!arst_n)
      reg_we && reg_addr == OFS_OUTBUF && !host.rd |=> !out_empt_reg[$past(reg_wdata[9:8])])
      else $error("empty flag not cleared");
   a_agg_full: assert property (@(posedge clk) disable iff (!arst_n)
      reg_re && reg_addr == OFS_STATUS |=> reg_rdata[BIT_IN_ALL_FULL] == &$past(in_full_reg))
      else $error("aggregate full wrong");
   a_agg_empty: assert property (@(posedge clk) disable iff (!arst_n)
      reg_re && reg_addr == OFS_STATUS |=> reg_rdata[BIT_OUT_ALL_EMPT] == &$past(out_empt_reg))
      else $error("aggregate empty wrong");
   a_hi_zero: assert property (@(posedge clk) disable iff (!arst_n)
      reg_re && reg_addr != OFS_CTRL |=> reg_rdata[31:16] == 16'h0000)
      else $error("upper bits not zero");
   a_master_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !slave_mode && !reg_we && !reg_re |=> $stable(in_full_reg) && $stable(out_empt_reg))
      else $error("flags moved in master mode");
   a_split_rd: assert property (@(posedge clk) disable iff (!arst_n)
      slave_mode && host.rd && !split_en && !reg_we |=> $stable(rdin_reg))
      else $error("read-data register used without split-buffer");

   c_overflow: cover property (@(posedge clk) disable iff (!arst_n) ovf_reg && irq);
   c_all_full: cover property (@(posedge clk) disable iff (!arst_n) in_all_full);
   c_underflow: cover property (@(posedge clk) disable iff (!arst_n) unf_reg);
   c_buf3_irq: cover property (@(posedge clk) disable iff (!arst_n) ist_reg[EV_BUF3]);
   c_all_empty: cover property (@(posedge clk) disable iff (!arst_n) out_all_empty && unf_reg);

endmodule

`default_nettype wire

/* bench/psbs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External host on the slave port
// ----------------------------------------
module psbs_host_model
   import psbs_pkg::*;
(
   input  wire logic       clk,
   output var  psbs_host_t host
);
   initial host = '0;

   // One-cycle strobe; write and read are never raised together
   task automatic drive(input logic w, input logic [1:0] i, input logic [7:0] d);
      @(posedge clk);
      host <= {w, !w, i, d};
   endtask

   // Released lines show the inverse, so a stale value cannot pass as data
   task automatic idle();
      @(posedge clk);
      host <= {1'b0, 1'b0, ~host.addr, ~host.data};
   endtask
endmodule
`default_nettype wire

/* bench/test_psbs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_psbs_top;
   import psbs_pkg::*;
   logic            clk;
   logic            arst_n;
   logic [7:0]      reg_addr;
   logic [31:0]     reg_wdata;
   logic            reg_we;
   logic            reg_re;
   logic [31:0]     reg_rdata;
   psbs_host_t      host;
   logic [7:0]      host_rdata;
   logic [ADDR_W:0] port_address;
   logic            port_chip_select_pin;
   logic            irq;
   int              miscompares;
   int              checks_done;
   int              cycles;
   logic [3:0]      full;
   logic [3:0]      empt;
   logic            ov;
   logic            un;
   logic            ev3;
   logic            sel3;
   logic [7:0]      b [4];
   logic [7:0]      ob [4];
   logic [7:0]      last;
   logic [7:0]      keep;
   logic [31:0]     v;
   logic [31:0]     r;
   logic [31:0]     wa;
   logic [31:0]     ra;
   logic [31:0]     pa;

   psbs_top i_psbs_top (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .host(host), .host_rdata(host_rdata), .port_address(port_address),
      .port_chip_select_pin(port_chip_select_pin), .irq(irq));
   psbs_host_model i_psbs_host_model (.clk(clk), .host(host));

   // ----------------------------------------
   // Checking and bus helpers
   // ----------------------------------------
   task automatic conclude();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk1(input string what, input logic e, input logic g);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %b seen %b", what, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      reg_re    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_re    <= 1'b0;
      #1 q = reg_rdata;
   endtask

   function automatic logic [31:0] stat();
      return {16'h0000, &full, ov, 2'b00, full, &empt, un, 2'b00, empt};
   endfunction

   task automatic chk_stat();
      rd(OFS_STATUS, 32'h0, r);
      chk("status", stat(), r);
   endtask

   task automatic hop(input logic w, input logic [1:0] a, input logic [7:0] d);
      i_psbs_host_model.drive(w, a, d);
      i_psbs_host_model.idle();
   endtask

   task automatic hwr(input logic [1:0] i, input logic [1:0] a, input logic [7:0] d);
      hop(1'b1, a, d);
      if (full[i])
         ov = 1'b1;
      else
      begin
         full[i] = 1'b1;
         b[i]    = d;
      end
      ev3 = ev3 | (sel3 & (i == 2'd3));
   endtask

   task automatic hrd(input logic [1:0] i);
      hop(1'b0, i, 8'h00);
      #1;
      // An empty buffer still hands out its stale byte
      if (empt[i])
         un = 1'b1;
      last    = ob[i];
      empt[i] = 1'b1;
      ev3     = ev3 | (sel3 & (i == 2'd3));
      chk("host byte", {24'h0, last}, {24'h0, host_rdata});
   endtask

   // ----------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         miscompares++;
         conclude();
      end
   end

   initial
   begin
      {arst_n, reg_we, reg_re, reg_addr, reg_wdata} = '0;
      {checks_done, miscompares} = '0;
      {full, ov, un, ev3, sel3, last} = '0;
      empt = 4'hF;
      v = $urandom(96);
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      chk_stat();
      chk1("irq", 1'b0, irq);
      // Legacy mode: the pointer steps 0..3 and wraps into a full buffer
      wr(OFS_CTRL, 32'h0000_1800);
      for (int i = 0; i < 5; i++)
      begin
         v = $urandom;
         hwr(2'(i), ~2'(i), v[7:0]);
         chk_stat();
      end
      rd(OFS_IRQ_STAT, 32'h0, r);
      chk("irq status", 32'h1, r);
      chk1("irq", 1'b0, irq);
      wr(OFS_IRQ_MASK, 32'h7);
      #1 chk1("irq", 1'b1, irq);
      wr(OFS_IRQ_STAT, 32'h1);
      #1 chk1("irq", 1'b0, irq);
      wr(OFS_STATUS, 32'h0000_4000);
      ov = 1'b0;
      chk_stat();
      for (int i = 0; i < 4; i++)
      begin
         rd(OFS_INBUF, i, r);
         chk("input byte", {24'h0, b[i]}, r);
         full[i] = 1'b0;
         chk_stat();
      end
      // Enhanced mode, buffer-3 interrupt selected
      wr(OFS_CTRL, 32'h0000_4100);
      sel3 = 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         v = $urandom;
         hwr(v[9:8], v[9:8], v[7:0]);
         chk_stat();
      end
      for (int i = 0; i < 4; i++)
      begin
         v = $urandom;
         wr(OFS_OUTBUF, {22'h0, 2'(i), v[7:0]});
         ob[i]   = v[7:0];
         empt[i] = 1'b0;
         chk_stat();
      end
      for (int i = 0; i < 8; i++)
      begin
         v = $urandom;
         hrd(i < 6 ? v[1:0] : 2'd3);
         chk_stat();
      end
      rd(OFS_IRQ_STAT, 32'h0, r);
      chk("irq status", {29'h0, ev3, un, ov}, r);
      chk1("irq", ev3 | un | ov, irq);
      // Split address and read-data registers
      wa = $urandom;
      ra = $urandom;
      wr(OFS_WRITE_TARGET_ADDRESS, wa);
      wr(OFS_READ_TARGET_ADDRESS, ra);
      wa = wa & 32'h0000_47FF;
      ra = ra & 32'h0000_47FF;
      rd(OFS_WRITE_TARGET_ADDRESS, 32'h0, r);
      chk("write address", wa, r);
      rd(OFS_READ_TARGET_ADDRESS, 32'h0, r);
      chk("read address", ra, r);
      v = $urandom;
      wr(OFS_RDIN, v);
      rd(OFS_RDIN, 32'h0, r);
      chk("read data reg", v & 32'h0000_FFFF, r);
      rd(8'h3C, 32'h0, r);
      chk("unmapped", 32'h0, r);
      sel3 = 1'b0;
      for (int s = 1; s >= 0; s--)
      begin
         wr(OFS_CTRL, {14'h0, s[0], 17'h0100});
         v = $urandom;
         wr(OFS_OUTBUF, {24'h0, v[7:0]});
         i_psbs_host_model.drive(1'b0, 2'd0, 8'h00);
         #1;
         pa = s[0] ? ra : wa;
         chk("port address", {21'h0, pa[10:0]}, {21'h0, port_address[10:0]});
         chk1("chip select", pa[14], port_chip_select_pin);
         chk1("line 14", s[0] && !ra[14] && ra[10], port_address[11]);
         i_psbs_host_model.idle();
         last    = v[7:0];
         ob[0]   = v[7:0];
         empt[0] = 1'b1;
         if (s == 1)
            keep = v[7:0];
         rd(s[0] ? OFS_RDIN : OFS_SHARED_IN, 32'h0, r);
         chk("captured byte", {24'h0, v[7:0]}, {24'h0, r[7:0]});
      end
      rd(OFS_RDIN, 32'h0, r);
      chk("read data reg", {24'h0, keep}, {24'h0, r[7:0]});
      // Legacy host reads follow the read pointer, which starts at buffer 0
      wr(OFS_CTRL, 32'h0000_1800);
      for (int i = 0; i < 2; i++)
         hrd(2'(i));
      chk_stat();
      wr(OFS_STATUS, 32'h0000_0040);
      un = 1'b0;
      chk_stat();
      // Master mode: host strobes are ignored
      wr(OFS_CTRL, 32'h0000_0300);
      hop(1'b1, 2'd1, 8'h5A);
      hop(1'b0, 2'd2, 8'h00);
      chk_stat();
      chk("host byte", {24'h0, last}, {24'h0, host_rdata});
      conclude();
   end
endmodule
`default_nettype wire
